/* irqt_defs.svh */
// register offsets, field positions, codes and reset values
`ifndef IRQT_DEFS_SVH
`define IRQT_DEFS_SVH

// register byte offsets
`define IRQT_OFF_FLAGS      8'h00
`define IRQT_OFF_ENABLE     8'h04
`define IRQT_OFF_GLOBAL     8'h08
`define IRQT_OFF_EDGE       8'h0C
`define IRQT_OFF_PSC        8'h10
`define IRQT_OFF_TICK0      8'h14
`define IRQT_OFF_TICK1      8'h18
`define IRQT_OFF_STATUS     8'h1C

// source bit positions in flag and enable registers
`define IRQT_SRC_EXT0       0
`define IRQT_SRC_PLT0       2
`define IRQT_SRC_ADC        4
`define IRQT_SRC_USIM       5
`define IRQT_SRC_TB0        6
`define IRQT_NUM_SRC        8
`define IRQT_NUM_CH         2

// edge select codes
`define IRQT_EDGE_OFF       2'b00
`define IRQT_EDGE_RISE      2'b01
`define IRQT_EDGE_FALL      2'b10
`define IRQT_EDGE_BOTH      2'b11

// prescaler source codes and divider
`define IRQT_PSC_SYS        2'b00
`define IRQT_PSC_DIV4       2'b01
`define IRQT_PSC_DIV4_LAST  2'h3

// tick control fields
`define IRQT_TICK_ON_BIT    7
`define IRQT_TICK_BASE      16'h0100
`define IRQT_TICK_CNT_W     15

// reset values and bus answers
`define IRQT_RST_BYTE       8'h00
`define IRQT_RESP_OKAY      2'b00
`define IRQT_RESP_SLVERR    2'b10

`endif

/* irqt_pkg.sv */
// shared types of the interrupt source block
package irqt_pkg;
  typedef enum logic [1:0] {SER_SPI, SER_I2C, SER_UART} irqt_ser_mode_t;
  typedef logic [7:0] irqt_byte_t;
  typedef logic [2:0] irqt_vec_t;
endpackage

/* irqt_edge_det.sv */
// external pin synchroniser and edge detector
`timescale 1ns/100ps
`include "irqt_defs.svh"
module irqt_edge_det (
  // clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       ce,
  // pin and control
  input  logic       pin_in,
  input  logic [1:0] edge_sel,
  input  logic       fn_active,
  // event
  output logic       edge_event
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic event_q;
  logic rise_w;
  logic fall_w;
  logic hit_w;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end
    else if (ce)
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise_w = sync2_q & ~prev_q;
  assign fall_w = ~sync2_q & prev_q;

  always_comb
  begin
    unique case (edge_sel)
      `IRQT_EDGE_OFF:  hit_w = 1'b0;
      `IRQT_EDGE_RISE: hit_w = rise_w;
      `IRQT_EDGE_FALL: hit_w = fall_w;
      `IRQT_EDGE_BOTH: hit_w = rise_w | fall_w;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_q <= 1'b0;
    else if (ce)
      event_q <= fn_active & hit_w;
  end

  assign edge_event = event_q;

  a_edge_off_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && edge_sel == `IRQT_EDGE_OFF |=> !edge_event)
    else $error("edge event while edge select is off");

  a_edge_rise_hit: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && fn_active && edge_sel == `IRQT_EDGE_RISE && rise_w |=> edge_event)
    else $error("rising edge not reported");
endmodule

/* irqt_tick_unit.sv */
// periodic tick divider with power-of-two period
`timescale 1ns/100ps
`include "irqt_defs.svh"
module irqt_tick_unit (
  // clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       ce,
  // prescaler and control
  input  logic       psc_tick,
  input  logic       unit_en,
  input  logic [2:0] period_sel,
  // overflow
  output logic       overflow
);
  logic [`IRQT_TICK_CNT_W-1:0] cnt_q;
  logic [`IRQT_TICK_CNT_W-1:0] last_w;
  logic                        ovf_q;
  logic                        term_w;

  assign last_w = `IRQT_TICK_CNT_W'((`IRQT_TICK_BASE << period_sel) - 16'h0001);
  assign term_w = (cnt_q == last_w);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end
    else if (ce)
    begin
      if (!unit_en)
      begin
        cnt_q <= '0;
        ovf_q <= 1'b0;
      end
      else
      begin
        ovf_q <= psc_tick & term_w;
        if (psc_tick)
          cnt_q <= term_w ? '0 : cnt_q + 1'b1;
      end
    end
  end

  assign overflow = ovf_q;

  a_tick_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && !unit_en |=> cnt_q == '0 && !overflow)
    else $error("tick counter runs while disabled");

  a_tick_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && unit_en && psc_tick && cnt_q == last_w |=> overflow && cnt_q == '0)
    else $error("tick counter missed its overflow");
endmodule

/* irqt_top.sv */
// interrupt sources, request flags, vector request and tick units
//
// What this block does
// - external pin flag sets on the selected edge type.
// - external pin vectors only with global and pin enables set.
// - pin is an interrupt input only if enabled, selected and input.
// - vector request needs source enabled and return stack not full.
// - servicing an external pin clears its flag and global enable.
// - selected pull-up stays active while pin serves as interrupt.
// - edge select offers rising, falling, both, or disabled.
// - edge codes 00 off, 01 rise, 10 fall, 11 both; reset zero.
// - comparator flag sets on any change of comparator output.
// - servicing a comparator clears its flag and global enable.
// - conversion done flag sets when a conversion finishes.
// - servicing conversion done clears its flag and global enable.
// - each tick unit sets its flag on divider overflow.
// - servicing a tick clears its flag and global enable.
// - prescaler source 00 system, 01 system/4, 1x sub clock.
// - enabled tick overflows every 2^(8+period) prescaler clocks.
// - I2C mode sets serial flag on byte, address match, timeout; SPI mode only on spi_i2c_event[0].
// - UART mode sets serial flag on any of six UART conditions.
// - servicing serial interrupt clears its flag and global enable.
// - servicing leaves UART status flags untouched.
// - global enable low blocks vectoring; flags still recorded.
// - any flag rising wakes the device, regardless of enables.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "irqt_defs.svh"
module irqt_top (
  // clock, reset, clock enable
  input  logic                    aclk,
  input  logic                    aresetn,
  input  logic                    ce,
  // axi4-lite write
  input  logic [7:0]              s_axi_awaddr,
  input  logic                    s_axi_awvalid,
  output logic                    s_axi_awready,
  input  logic [31:0]             s_axi_wdata,
  input  logic [3:0]              s_axi_wstrb,
  input  logic                    s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  logic                    s_axi_bready,
  // axi4-lite read
  input  logic [7:0]              s_axi_araddr,
  input  logic                    s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  logic                    s_axi_rready,
  // external interrupt pins
  input  logic [1:0]              ext_pin_in,
  input  logic [1:0]              pin_share_sel,
  input  logic [1:0]              port_dir_input,
  input  logic [1:0]              pull_up_sel,
  output logic [1:0]              pull_up_en,
  // peripheral events
  input  logic [1:0]              plt_cmp_out,
  input  logic                    conv_done,
  input  irqt_pkg::irqt_ser_mode_t serial_mode,
  input  logic [3:0]              spi_i2c_event,
  input  logic [5:0]              uart_event,
  input  logic                    sub_clk_in,
  // cpu side
  input  logic                    stack_full,
  input  logic                    vector_ack,
  input  logic                    reti_pulse,
  output logic                    irq_req,
  output irqt_pkg::irqt_vec_t     irq_vector,
  output logic                    wake_pulse
);
  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic                aw_hold_q;
  logic                w_hold_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic [7:0]          awaddr_q;
  irqt_pkg::irqt_byte_t wdata_q;
  logic                wstrb0_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  irqt_pkg::irqt_byte_t rdata_q;
  logic                wr_commit_w;
  logic                wr_map_w;
  logic                wr_byte_w;
  irqt_pkg::irqt_byte_t rd_byte_w;
  logic                rd_map_w;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign wr_commit_w   = aw_hold_q & w_hold_q;
  assign wr_byte_w     = wr_commit_w & wstrb0_q;
  assign wr_map_w      = (awaddr_q[7:5] == 3'h0) && (awaddr_q[1:0] == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `IRQT_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= `IRQT_RST_BYTE;
      wstrb0_q  <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_commit_w)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map_w ? `IRQT_RESP_OKAY : `IRQT_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `IRQT_RESP_OKAY;
      rdata_q  <= `IRQT_RST_BYTE;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_byte_w;
        rresp_q  <= rd_map_w ? `IRQT_RESP_OKAY : `IRQT_RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = {24'h000000, rdata_q};

  // ****************************************************************
  // control registers
  // ****************************************************************
  irqt_pkg::irqt_byte_t flag_q;
  irqt_pkg::irqt_byte_t flag_d;
  irqt_pkg::irqt_byte_t en_q;
  irqt_pkg::irqt_byte_t en_d;
  logic                glob_q;
  logic                glob_d;
  logic [3:0]          edge_q;
  logic [1:0]          psc_sel_q;
  logic [1:0]          tick_on_q;
  logic [2:0]          tick_per_q [`IRQT_NUM_CH];
  logic                wr_flag_w;
  logic                wr_en_w;
  logic                wr_glob_w;

  assign wr_flag_w = wr_byte_w && awaddr_q == `IRQT_OFF_FLAGS;
  assign wr_en_w   = wr_byte_w && awaddr_q == `IRQT_OFF_ENABLE;
  assign wr_glob_w = wr_byte_w && awaddr_q == `IRQT_OFF_GLOBAL;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_q    <= 4'h0;
      psc_sel_q <= 2'h0;
      tick_on_q <= 2'h0;
      for (int i = 0; i < `IRQT_NUM_CH; i++)
        tick_per_q[i] <= 3'h0;
    end
    else if (ce && wr_byte_w)
    begin
      if (awaddr_q == `IRQT_OFF_EDGE)
        edge_q <= wdata_q[3:0];
      if (awaddr_q == `IRQT_OFF_PSC)
        psc_sel_q <= wdata_q[1:0];
      if (awaddr_q == `IRQT_OFF_TICK0)
      begin
        tick_on_q[0]  <= wdata_q[`IRQT_TICK_ON_BIT];
        tick_per_q[0] <= wdata_q[2:0];
      end
      if (awaddr_q == `IRQT_OFF_TICK1)
      begin
        tick_on_q[1]  <= wdata_q[`IRQT_TICK_ON_BIT];
        tick_per_q[1] <= wdata_q[2:0];
      end
    end
  end

  always_comb
  begin
    rd_map_w = 1'b1;
    unique case (s_axi_araddr)
      `IRQT_OFF_FLAGS:  rd_byte_w = flag_q;
      `IRQT_OFF_ENABLE: rd_byte_w = en_q;
      `IRQT_OFF_GLOBAL: rd_byte_w = {7'h00, glob_q};
      `IRQT_OFF_EDGE:   rd_byte_w = {4'h0, edge_q};
      `IRQT_OFF_PSC:    rd_byte_w = {6'h00, psc_sel_q};
      `IRQT_OFF_TICK0:  rd_byte_w = {tick_on_q[0], 4'h0, tick_per_q[0]};
      `IRQT_OFF_TICK1:  rd_byte_w = {tick_on_q[1], 4'h0, tick_per_q[1]};
      `IRQT_OFF_STATUS: rd_byte_w = {4'h0, irq_vector, irq_req};
      default:
      begin
        rd_byte_w = 8'h00;
        rd_map_w  = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // event sources
  // ****************************************************************
  irqt_pkg::irqt_byte_t ev_w;
  logic [1:0]          plt_s1_q;
  logic [1:0]          plt_s2_q;
  logic [1:0]          plt_prev_q;
  logic [1:0]          pull_q;
  logic                sub_s1_q;
  logic                sub_s2_q;
  logic                sub_prev_q;
  logic [1:0]          div4_q;
  logic                psc_tick_w;
  logic                ser_ev_w;

  genvar g;
  generate
    for (g = 0; g < `IRQT_NUM_CH; g++)
    begin : g_ch
      irqt_edge_det u_edge (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .pin_in     (ext_pin_in[g]),
        .edge_sel   (edge_q[2*g+1:2*g]),
        .fn_active  (en_q[`IRQT_SRC_EXT0+g] & pin_share_sel[g]
                     & port_dir_input[g]),
        .edge_event (ev_w[`IRQT_SRC_EXT0+g])
      );
      irqt_tick_unit u_tick (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .psc_tick   (psc_tick_w),
        .unit_en    (tick_on_q[g]),
        .period_sel (tick_per_q[g]),
        .overflow   (ev_w[`IRQT_SRC_TB0+g])
      );
      assign ev_w[`IRQT_SRC_PLT0+g] = plt_s2_q[g] ^ plt_prev_q[g];
    end
  endgenerate

  assign ev_w[`IRQT_SRC_ADC]  = conv_done;
  assign ev_w[`IRQT_SRC_USIM] = ser_ev_w;

  always_comb
  begin
    unique case (serial_mode)
      irqt_pkg::SER_SPI:  ser_ev_w = spi_i2c_event[0];
      irqt_pkg::SER_I2C:  ser_ev_w = |spi_i2c_event;
      irqt_pkg::SER_UART: ser_ev_w = |uart_event;
      default:            ser_ev_w = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      plt_s1_q   <= 2'h0;
      plt_s2_q   <= 2'h0;
      plt_prev_q <= 2'h0;
      sub_s1_q   <= 1'b0;
      sub_s2_q   <= 1'b0;
      sub_prev_q <= 1'b0;
      div4_q     <= 2'h0;
      pull_q     <= 2'h0;
    end
    else if (ce)
    begin
      plt_s1_q   <= plt_cmp_out;
      plt_s2_q   <= plt_s1_q;
      plt_prev_q <= plt_s2_q;
      sub_s1_q   <= sub_clk_in;
      sub_s2_q   <= sub_s1_q;
      sub_prev_q <= sub_s2_q;
      div4_q     <= div4_q + 2'h1;
      pull_q     <= pull_up_sel;
    end
  end

  assign pull_up_en = pull_q;

  always_comb
  begin
    if (psc_sel_q == `IRQT_PSC_SYS)
      psc_tick_w = 1'b1;
    else if (psc_sel_q == `IRQT_PSC_DIV4)
      psc_tick_w = (div4_q == `IRQT_PSC_DIV4_LAST);
    else
      psc_tick_w = sub_s2_q & ~sub_prev_q;
  end

  // ****************************************************************
  // flags, enables and vector request
  // ****************************************************************
  irqt_pkg::irqt_byte_t svc_clr_w;
  irqt_pkg::irqt_byte_t pend_w;
  irqt_pkg::irqt_vec_t  vec_q;
  irqt_pkg::irqt_vec_t  vec_d;
  logic                req_q;
  logic                req_d;
  logic                wake_q;
  logic                svc_take_w;

  assign irq_req     = req_q & ~stack_full;
  assign irq_vector  = vec_q;
  assign wake_pulse  = wake_q;
  assign svc_take_w  = irq_req & vector_ack;
  // only this block's flag is cleared; uart status stays with the uart
  assign svc_clr_w   = svc_take_w ? 8'(8'h01 << vec_q) : 8'h00;
  assign flag_d      = ((wr_flag_w ? wdata_q : flag_q) & ~svc_clr_w)
                       | ev_w;
  assign en_d        = wr_en_w ? wdata_q : en_q;
  assign pend_w      = flag_d & en_d;

  always_comb
  begin
    glob_d = glob_q;
    if (wr_glob_w)
      glob_d = wdata_q[0];
    if (reti_pulse)
      glob_d = 1'b1;
    if (svc_take_w)
      glob_d = 1'b0;
  end

  always_comb
  begin
    vec_d = 3'h0;
    for (int i = `IRQT_NUM_SRC - 1; i >= 0; i--)
      if (pend_w[i])
        vec_d = 3'(i);
  end

  assign req_d = glob_d & (|pend_w);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= `IRQT_RST_BYTE;
      en_q   <= `IRQT_RST_BYTE;
      glob_q <= 1'b0;
      req_q  <= 1'b0;
      vec_q  <= 3'h0;
      wake_q <= 1'b0;
    end
    else if (ce)
    begin
      flag_q <= flag_d;
      en_q   <= en_d;
      glob_q <= glob_d;
      req_q  <= req_d;
      vec_q  <= vec_d;
      wake_q <= |(flag_d & ~flag_q);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_req_gated: assert property (
    @(posedge aclk) disable iff (!aresetn)
    irq_req |-> glob_q && !stack_full && (flag_q & en_q) != 8'h00
                && flag_q[vec_q] && en_q[vec_q])
    else $error("request without enabled pending source");

  a_svc_global: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && svc_take_w |=> !glob_q && !req_q)
    else $error("global enable survived a service");

  a_svc_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && svc_take_w && !wr_flag_w && (ev_w & svc_clr_w) == 8'h00
    |=> (flag_q & $past(svc_clr_w)) == 8'h00)
    else $error("serviced flag not cleared");

  a_event_sets: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && ev_w != 8'h00 |=> (flag_q & $past(ev_w)) == $past(ev_w))
    else $error("event did not set its flag");

  a_wake_rise: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && (flag_d & ~flag_q) != 8'h00 |=> wake_pulse)
    else $error("flag rise gave no wake pulse");

  a_usim_uart: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && serial_mode == irqt_pkg::SER_UART && uart_event != 6'h00
    |=> flag_q[`IRQT_SRC_USIM])
    else $error("uart condition did not set serial flag");

  a_psc_div4: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && psc_sel_q == `IRQT_PSC_DIV4 && psc_tick_w ##1 ce
    |-> !psc_tick_w || psc_sel_q != `IRQT_PSC_DIV4)
    else $error("divide by four prescaler ticks twice in a row");

  a_pull_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce |=> pull_up_en == $past(pull_up_sel))
    else $error("pull-up selection not kept");
endmodule

/* irqt_periph_model.sv */
// pin, comparator and peripheral event model for the interrupt sources
`timescale 1ns/100ps
module irqt_periph_model (
  // clock
  input  wire logic       aclk,
  // pins and comparators
  output logic      [1:0] ext_pin_in,
  output logic      [1:0] plt_cmp_out,
  output logic            sub_clk_in,
  // one-cycle events
  output logic            conv_done,
  output logic      [3:0] spi_i2c_event,
  output logic      [5:0] uart_event
);
  initial
  begin
    ext_pin_in = 2'h0;
    plt_cmp_out = 2'h0;
    sub_clk_in = 1'b0;
    {conv_done, spi_i2c_event, uart_event} = 11'h000;
    // free running sub oscillator, offset so no edge meets an aclk edge
    #0.5;
    forever #11 sub_clk_in = ~sub_clk_in;
  end
  task pins(input logic [1:0] p, input logic [1:0] c);
    @(posedge aclk);
    ext_pin_in <= p;
    plt_cmp_out <= c;
  endtask
  task pulse(input logic [10:0] m);
    @(posedge aclk);
    {conv_done, spi_i2c_event, uart_event} <= m;
    @(posedge aclk);
    {conv_done, spi_i2c_event, uart_event} <= 11'h000;
  endtask
endmodule

/* irqt_top_tb.sv */
// self-checking bench for the interrupt source block
`timescale 1ns/100ps
module irqt_top_tb;
  // ****************
  // signals
  // ****************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  dir_in = 2'h3, share = 2'h3, pu_sel = 2'h0;
  logic [1:0]  pu_en, bresp, rresp, pin, cmp;
  logic        stack_full = 1'b0, ack = 1'b0, conv, sub_clk;
  logic        awready, wready, bvalid, arready, rvalid, irq_req, wake;
  logic [31:0] rdata;
  logic [2:0]  vec;
  logic [3:0]  spi_ev;
  logic [5:0]  uart_ev;
  logic [7:0]  d;
  irqt_pkg::irqt_ser_mode_t mode = irqt_pkg::SER_UART;
  int          errors = 0, samples_checked = 0, cyc = 0, t0, s;
  int          seed = 32'h3F79;
  int          src[6] = '{0, 2, 4, 5, 5, 5};

  irqt_top i_irqt_top (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pin_in(pin),
    .pin_share_sel(share), .port_dir_input(dir_in), .pull_up_sel(pu_sel),
    .pull_up_en(pu_en), .plt_cmp_out(cmp), .conv_done(conv),
    .serial_mode(mode), .spi_i2c_event(spi_ev), .uart_event(uart_ev),
    .sub_clk_in(sub_clk), .stack_full(stack_full), .vector_ack(ack),
    .reti_pulse(1'b0), .irq_req(irq_req), .irq_vector(vec),
    .wake_pulse(wake));
  irqt_periph_model i_irqt_periph_model (.aclk(aclk), .ext_pin_in(pin),
    .plt_cmp_out(cmp), .sub_clk_in(sub_clk), .conv_done(conv),
    .spi_i2c_event(spi_ev), .uart_event(uart_ev));

  always #2 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ****************
  // tasks
  // ****************
  task report_and_stop;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic edge_hit(input logic [1:0] c, input logic r);
    return (c == 2'h3) || (c == 2'h1 && r) || (c == 2'h2 && !r);
  endfunction
  // sub clock rises every 22 ns, that is 5.5 aclk cycles
  function automatic int tick_gap(input int p, input int psc);
    if (psc >= 2)
      return ((256 << p) * 11) / 2;
    return (256 << p) * ((psc == 1) ? 4 : 1);
  endfunction
  task idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wait_wake;
    do @(posedge aclk); while (wake !== 1'b1);
  endtask
  task axi_wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(e));
  endtask
  task axi_rd(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h000000, v});
    chk(32'(rresp), 32'(e));
  endtask
  task fire(input int k);
    case (k)
      0: i_irqt_periph_model.pins(pin ^ 2'h1, cmp);
      2: i_irqt_periph_model.pins(pin, cmp ^ 2'h1);
      4: i_irqt_periph_model.pulse(11'h400);
      default: i_irqt_periph_model.pulse((mode == irqt_pkg::SER_UART)
                 ? 11'h004 : (mode == irqt_pkg::SER_SPI) ? 11'h040 : 11'h100);
    endcase
  endtask
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 32; a += 4)
      axi_rd(8'(a), 8'h00, 2'h0);
    axi_rd(8'h20, 8'h00, 2'h2);
    axi_wr(8'h21, 8'h00, 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      axi_wr(8'h04, d, 2'h0);
      axi_rd(8'h04, d, 2'h0);
      pu_sel <= d[1:0];
      idle(2);
      chk(32'(pu_en), 32'(d[1:0]));
    end
    axi_wr(8'h04, 8'h01, 2'h0);
    for (int c = 0; c < 4; c++)
    begin
      axi_wr(8'h0C, 8'(c), 2'h0);
      for (int r = 1; r >= 0; r--)
      begin
        axi_wr(8'h00, 8'h00, 2'h0);
        i_irqt_periph_model.pins({1'b0, r[0]}, cmp);
        idle(8);
        axi_rd(8'h00, {7'h00, edge_hit(c[1:0], r[0])}, 2'h0);
      end
    end
    axi_wr(8'h00, 8'h00, 2'h0);
    for (int i = 0; i < 2; i++)
    begin
      {share, dir_in} <= (i == 1) ? 4'hB : 4'hE;
      fire(0);
      idle(8);
      axi_rd(8'h00, 8'h00, 2'h0);
    end
    {share, dir_in} <= 4'hF;
    for (int i = 0; i < 6; i++)
    begin
      s = src[i];
      mode <= (i < 4) ? irqt_pkg::SER_UART
              : (i == 4) ? irqt_pkg::SER_SPI : irqt_pkg::SER_I2C;
      axi_wr(8'h00, 8'h00, 2'h0);
      axi_wr(8'h04, 8'(1 << s), 2'h0);
      axi_wr(8'h08, 8'h01, 2'h0);
      stack_full <= 1'b1;
      fire(s);
      idle(8);
      chk(32'(irq_req), 32'h0);
      stack_full <= 1'b0;
      idle(2);
      chk(32'(irq_req), 32'h1);
      chk(32'(vec), 32'(s));
      ack <= 1'b1;
      idle(1);
      ack <= 1'b0;
      idle(2);
      axi_rd(8'h00, 8'h00, 2'h0);
      axi_rd(8'h08, 8'h00, 2'h0);
    end
    axi_wr(8'h04, 8'h04, 2'h0);
    fire(2);
    idle(8);
    chk(32'(irq_req), 32'h0);
    axi_rd(8'h00, 8'h04, 2'h0);
    axi_wr(8'h04, 8'h00, 2'h0);
    for (int k = 0; k < 3; k++)
    begin
      s = (k == 2) ? 1 : 0;
      axi_wr(8'h00, 8'h00, 2'h0);
      axi_wr(8'h10, 8'(2 - k), 2'h0);
      axi_wr(8'(8'h14 + 4 * (k % 2)), 8'h80 | 8'(s), 2'h0);
      wait_wake;
      t0 = cyc;
      axi_wr(8'h00, 8'h00, 2'h0);
      wait_wake;
      chk(32'(cyc - t0), 32'(tick_gap(s, 2 - k)));
      axi_wr(8'(8'h14 + 4 * (k % 2)), 8'h00, 2'h0);
    end
    axi_wr(8'h00, 8'h00, 2'h0);
    idle(1100);
    axi_rd(8'h00, 8'h00, 2'h0);
    report_and_stop();
  end
endmodule
